// ### src/dslmon_pkg.sv
/*
 * constants shared by the dsl link monitor: register map, fields,
 * loopback modes and the one-second timing.
 * assumes a 40 MHz aclk and a 32-bit axi4-lite register bus.
 */
package dslmon_pkg;
	// register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] ERRSEC_OFS  = 8'h08;
	localparam logic [7:0] SEVSEC_OFS  = 8'h0c;
	localparam logic [7:0] UNAVSEC_OFS = 8'h10;
	localparam logic [7:0] SNR_OFS  = 8'h14;
	// control fields: mode[2:0], e1 fitted, counter clear (write only)
	localparam int CTRL_E1_BIT  = 4;
	localparam int CTRL_CLR_BIT = 8;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// frame checks
	localparam int          CRC_W        = 6;
	localparam logic [5:0]  CRC_POLY     = 6'h03;
	localparam logic [2:0]  SYNC_BAD_MAX = 3'h5;
	localparam logic [7:0]  SEVERE_LIMIT = 8'h96;
	// one-second tick
	localparam longint SEC_NS      = 1000000000;
	localparam longint CLK_NS      = 25;
	localparam int     SEC_CYCLES  = int'(SEC_NS / CLK_NS);
	localparam int     CNT_W       = 16;
	// loopback modes
	typedef enum logic [2:0] {
		LB_NONE,
		LB_LOCAL,
		LB_DSL,
		LB_REMOTE,
		LB_SELF
	} lb_mode_t;
endpackage

// ### src/dsl_link_monitor_loopback.sv
/*
 * dsl link performance monitor and loopback controller: check-word and
 * sync-word checking, second classification, alarms, e1 status and the
 * four loopback modes, with an axi4-lite register slave.
 * assumes framer, e1 and line logic share aclk; strobes are 1-cycle.
 */
//
// Overview of operation
// - sender appends 6-bit check word per frame
// - receiver recomputes check word, mismatch errors second
// - insert sync word into every sent frame
// - five bad sync words in row: sync lost
// - one check error makes errored second
// - 150 check errors make severely errored second
// - any local sync loss makes unavailable second
// - second counters accumulate until explicitly cleared
// - refresh signal-to-noise value every second
// - line alarm on sync loss until resync
// - report local and remote sync loss separately
// - flag e1 alignment, bipolar, ones, crc, carrier
// - e1 status: coding, frame, carrier, yellow, sync
// - local loopback returns port data to port
// - e1 in-band pattern also enters local loopback
// - dsl loopback returns line data to line
// - remote loopback: far unit loops our traffic
// - dsl loopback opens line, losing sync
// - releasing any loopback retrains the link
// - selftest loops internally, then link re-established
// - same rate both directions on one pair
`timescale 1ns/1ps
module dsl_link_monitor_loopback #(
	parameter int SEC_CYC = dslmon_pkg::SEC_CYCLES,
	parameter int CW      = dslmon_pkg::CNT_W
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        tx_start,
	input  wire logic        tx_bit_valid,
	input  wire logic        tx_cover,
	input  wire logic        tx_crc_slot,
	input  wire logic        tx_sync_slot,
	input  wire logic        tx_sync_pat,
	output logic             tx_line_bit,
	input  wire logic        rx_bit_valid,
	input  wire logic        rx_bit,
	input  wire logic        rx_cover,
	input  wire logic        rx_crc_slot,
	input  wire logic        rx_sync_slot,
	input  wire logic        rx_sync_pat,
	input  wire logic        rx_frame_end,
	input  wire logic        dsl_rx_data,
	input  wire logic        lp_rx,
	output logic             lp_tx,
	input  wire logic        remote_sync_lost_in,
	input  wire logic [7:0]  snr_in,
	input  wire logic [7:0]  e1_flags,
	input  wire logic        e1_inband_loop,
	output logic             line_alarm,
	output logic [2:0]       loop_mode,
	output logic             line_open,
	output logic             loop_internal,
	output logic             remote_loop_req,
	output logic             retrain
);
	import dslmon_pkg::*;

	logic [5:0]    crc_tx_r, crc_rx_r, crc_got_r;
	logic          sync_err_r, sync_lost_r, remote_lost_r;
	logic [2:0]    bad_cnt_r;
	logic [31:0]   tick_cnt_r;
	logic          tick;
	logic [7:0]    crc_cnt_r, snr_r, e1_r;
	logic          sec_unavail_r, crc_bad, frame_loss;
	logic [CW-1:0] errsec_r, sevsec_r, unavsec_r;
	lb_mode_t      mode_r, pend_r;
	logic          pend_vld_r, e1_fit_r, retrain_r;
	logic          wr_go, clr, mode_req;
	lb_mode_t      req_mode;
	logic [7:0]    aw_a_r;
	logic [31:0]   w_d_r;

	// one step of the serial check-word divider
	function automatic logic [5:0] crc_step(input logic [5:0] c, input logic b);
		crc_step = {c[4:0], 1'b0} ^ ((c[5] ^ b) ? CRC_POLY : 6'h00);
	endfunction

	// transmit framer: check word over covered bits, sync word in its slot
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			crc_tx_r    <= 6'h00;
			tx_line_bit <= 1'b1;
		end else if (tx_start) begin
			crc_tx_r <= 6'h00;
		end else if (tx_bit_valid) begin
			if (tx_sync_slot)
				tx_line_bit <= tx_sync_pat;
			else if (tx_crc_slot) begin
				tx_line_bit <= crc_tx_r[5];
				crc_tx_r    <= {crc_tx_r[4:0], 1'b0};
			end else begin
				// dsl loopback sends line data back; else port data
				tx_line_bit <= (mode_r == LB_DSL) ? dsl_rx_data : lp_rx;
				if (tx_cover)
					crc_tx_r <= crc_step(crc_tx_r, (mode_r == LB_DSL) ? dsl_rx_data : lp_rx);
			end
		end
	end

	// receive checker; registers restart after each frame end
	always_ff @(posedge aclk) begin
		if (!aresetn || rx_frame_end) begin
			crc_rx_r   <= 6'h00;
			crc_got_r  <= 6'h00;
			sync_err_r <= 1'b0;
		end else if (rx_bit_valid) begin
			if (rx_cover)
				crc_rx_r <= crc_step(crc_rx_r, rx_bit);
			if (rx_crc_slot)
				crc_got_r <= {crc_got_r[4:0], rx_bit};
			if (rx_sync_slot && (rx_bit != rx_sync_pat))
				sync_err_r <= 1'b1;
		end
	end

	assign crc_bad    = rx_frame_end && (crc_rx_r != crc_got_r);
	assign frame_loss = rx_frame_end && sync_err_r && (bad_cnt_r == SYNC_BAD_MAX - 3'h1);

	// sync loss after five errored sync words; one clean word regains it.
	// an open line (dsl loopback) forces loss; other mode changes leave sync alone.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bad_cnt_r   <= 3'h0;
			sync_lost_r <= 1'b0;
		end else if (mode_r == LB_DSL) begin
			sync_lost_r <= 1'b1;
			bad_cnt_r   <= 3'h0;
		end else if (rx_frame_end) begin
			if (!sync_err_r) begin
				bad_cnt_r   <= 3'h0;
				sync_lost_r <= 1'b0;
			end else if (frame_loss) begin
				bad_cnt_r   <= 3'h0;
				sync_lost_r <= 1'b1;
			end else
				bad_cnt_r <= bad_cnt_r + 3'h1;
		end
	end

	// free-running second divider
	always_ff @(posedge aclk) begin
		if (!aresetn || tick)
			tick_cnt_r <= 32'h0;
		else
			tick_cnt_r <= tick_cnt_r + 32'h1;
	end
	assign tick = (tick_cnt_r == 32'(SEC_CYC - 1));

	// per-second tallies; an event in the tick cycle opens the next second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			crc_cnt_r     <= 8'h00;
			sec_unavail_r <= 1'b0;
		end else if (tick) begin
			crc_cnt_r     <= {7'h00, crc_bad};
			sec_unavail_r <= frame_loss || sync_lost_r;
		end else begin
			if (crc_bad && crc_cnt_r != SEVERE_LIMIT)
				crc_cnt_r <= crc_cnt_r + 8'h01;
			if (frame_loss || sync_lost_r)
				sec_unavail_r <= 1'b1;
		end
	end

	// software writes to control
	assign wr_go    = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign clr      = wr_go && (aw_a_r == CTRL_OFS) && w_d_r[CTRL_CLR_BIT];
	assign req_mode = lb_mode_t'(w_d_r[2:0]);
	assign mode_req = wr_go && (aw_a_r == CTRL_OFS) && (req_mode != mode_r);

	// second counters: saturate, zero only on clear; a tick in the clear
	// cycle still counts so the event is not lost
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			errsec_r  <= '0;
			sevsec_r  <= '0;
			unavsec_r <= '0;
		end else begin
			if (tick && crc_cnt_r != 8'h00)
				errsec_r <= clr ? CW'(1) : (&errsec_r ? errsec_r : errsec_r + CW'(1));
			else if (clr)
				errsec_r <= '0;
			if (tick && crc_cnt_r >= SEVERE_LIMIT)
				sevsec_r <= clr ? CW'(1) : (&sevsec_r ? sevsec_r : sevsec_r + CW'(1));
			else if (clr)
				sevsec_r <= '0;
			if (tick && sec_unavail_r)
				unavsec_r <= clr ? CW'(1) : (&unavsec_r ? unavsec_r : unavsec_r + CW'(1));
			else if (clr)
				unavsec_r <= '0;
		end
	end

	// snr sample, remote loss and live e1 flags
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			snr_r         <= 8'h00;
			remote_lost_r <= 1'b0;
			e1_r          <= 8'h00;
		end else begin
			if (tick)
				snr_r <= snr_in;
			remote_lost_r <= remote_sync_lost_in;
			e1_r          <= e1_fit_r ? e1_flags : 8'h00;
		end
	end

	// loopback mode: a new request first drops the old loop for one cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_r     <= LB_NONE;
			pend_r     <= LB_NONE;
			pend_vld_r <= 1'b0;
			retrain_r  <= 1'b0;
			e1_fit_r   <= 1'b0;
		end else begin
			retrain_r <= 1'b0;
			if (wr_go && aw_a_r == CTRL_OFS)
				e1_fit_r <= w_d_r[CTRL_E1_BIT];
			if (pend_vld_r) begin
				mode_r     <= pend_r;
				pend_vld_r <= 1'b0;
			end else if (mode_req || (e1_inband_loop && e1_fit_r && mode_r != LB_LOCAL)) begin
				pend_r <= mode_req ? req_mode : LB_LOCAL;
				if (mode_r != LB_NONE) begin
					mode_r     <= LB_NONE;
					retrain_r  <= 1'b1;
					pend_vld_r <= (mode_req ? req_mode : LB_LOCAL) != LB_NONE;
				end else
					mode_r <= mode_req ? req_mode : LB_LOCAL;
			end
		end
	end

	// user-side outputs, all registered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lp_tx           <= 1'b1;
			line_open       <= 1'b0;
			loop_internal   <= 1'b0;
			remote_loop_req <= 1'b0;
		end else begin
			// selftest interrupts service: idle ones toward the port
			case (mode_r)
				LB_LOCAL: lp_tx <= lp_rx;
				LB_SELF:  lp_tx <= 1'b1;
				default:  lp_tx <= dsl_rx_data;
			endcase
			line_open       <= (mode_r == LB_DSL);
			loop_internal   <= (mode_r == LB_SELF);
			remote_loop_req <= (mode_r == LB_REMOTE);
		end
	end
	assign line_alarm = sync_lost_r;
	assign loop_mode  = mode_r;
	assign retrain    = retrain_r;

	// axi4-lite write: address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			aw_a_r        <= 8'h00;
			w_d_r         <= CTRL_RST;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_a_r        <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				// partial strobes keep control lanes from earlier writes
				for (int i = 0; i < 4; i++)
					if (s_axi_wstrb[i])
						w_d_r[i*8 +: 8] <= s_axi_wdata[i*8 +: 8];
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_a_r == CTRL_OFS) ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// axi4-lite read: one cycle to data, unmapped reads zero with slverr
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= RESP_OKAY;
			case (s_axi_araddr)
				CTRL_OFS: s_axi_rdata <= {27'h0, e1_fit_r, 1'b0, mode_r};
				STAT_OFS: s_axi_rdata <= {16'h0, e1_r, 5'h0, mode_r != LB_NONE, remote_lost_r, sync_lost_r};
				ERRSEC_OFS:  s_axi_rdata <= 32'(errsec_r);
				SEVSEC_OFS:  s_axi_rdata <= 32'(sevsec_r);
				UNAVSEC_OFS: s_axi_rdata <= 32'(unavsec_r);
				SNR_OFS:  s_axi_rdata <= {24'h0, snr_r};
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence bad_word_s;
		rx_frame_end && sync_err_r && mode_r != LB_DSL;
	endsequence
	sequence release_s;
		mode_r != LB_NONE && (mode_req || (e1_inband_loop && e1_fit_r && mode_r != LB_LOCAL)) && !pend_vld_r;
	endsequence

	sync_loss_a: assert property (bad_word_s and bad_cnt_r == 3'h4 |=> sync_lost_r)
		else $error("fifth bad sync word did not declare loss");
	sync_early_a: assert property (bad_word_s and bad_cnt_r < 3'h4 and !sync_lost_r |=> !sync_lost_r)
		else $error("sync loss declared early");
	alarm_hold_a: assert property (sync_lost_r && !rx_frame_end |=> sync_lost_r)
		else $error("line alarm dropped without resync");
	crc_cnt_a: assert property (crc_bad && !tick && crc_cnt_r < SEVERE_LIMIT
		|=> crc_cnt_r == $past(crc_cnt_r) + 8'h01)
		else $error("check error not tallied");
	errsec_inc_a: assert property (tick && crc_cnt_r != 8'h00 && !clr && !(&errsec_r)
		|=> errsec_r == $past(errsec_r) + CW'(1))
		else $error("errored second missed");
	sevsec_hold_a: assert property (tick && crc_cnt_r < SEVERE_LIMIT && !clr |=> $stable(sevsec_r))
		else $error("severe second counted below limit");
	unavsec_inc_a: assert property (tick && sec_unavail_r && !clr && !(&unavsec_r)
		|=> unavsec_r == $past(unavsec_r) + CW'(1))
		else $error("unavailable second missed");
	clear_zero_a: assert property (clr && !tick |=> errsec_r == '0 && sevsec_r == '0 && unavsec_r == '0)
		else $error("clear did not zero counters");
	errsec_sat_a: assert property (&errsec_r && !clr |=> &errsec_r)
		else $error("errored counter wrapped");
	snr_tick_a: assert property (tick |=> snr_r == $past(snr_in))
		else $error("snr not refreshed on tick");
	loop_release_a: assert property (release_s |=> retrain_r && mode_r == LB_NONE ##1 !retrain_r)
		else $error("loopback release without retrain");
	line_open_a: assert property (mode_r == LB_DSL |=> line_open && sync_lost_r)
		else $error("dsl loopback left line closed");
endmodule // dsl_link_monitor_loopback

// ### verif/dsl_peer_model.sv
/*
 * far-end transceiver model: sends dsl frames carrying a sync word and a
 * check word, one bit per slot. assumes aclk is the shared line bit clock.
 */
`timescale 1ns/1ps
module dsl_peer_model #(
	parameter logic [3:0] SYNC_WORD = 4'hb
) (
	input  wire logic aclk,
	output logic      rx_bit_valid,
	output logic      rx_bit,
	output logic      rx_cover,
	output logic      rx_crc_slot,
	output logic      rx_sync_slot,
	output logic      rx_sync_pat,
	output logic      rx_frame_end,
	output logic      dsl_rx_data
);
	logic [7:0] seq = 8'h00;

	// quiet line at start
	initial begin
		{rx_bit_valid, rx_cover, rx_crc_slot, rx_sync_slot, rx_sync_pat, rx_frame_end} = 6'h00;
		rx_bit = 1'b1;
		dsl_rx_data = 1'b1;
	end

	// frame: 4 sync, 8 covered payload, 6 check bits; faults flip one bit
	task automatic send_frame(input logic bad_crc, input logic bad_sync);
		logic [5:0] crc;
		logic       b;
		crc = 6'h00;
		seq = seq + 8'h3b;
		for (int i = 0; i < 18; i++) begin
			@(posedge aclk);
			if (i < 4) begin
				b = SYNC_WORD[3-i] ^ (bad_sync && i == 0);
			end else if (i < 12) begin
				b = seq[11-i];
				crc = {crc[4:0], 1'b0} ^ ((crc[5] ^ b) ? 6'h03 : 6'h00);
			end else begin
				b = crc[17-i] ^ (bad_crc && i == 17);
			end
			rx_bit_valid <= 1'b1;
			rx_sync_slot <= (i < 4);
			rx_sync_pat <= (i < 4) ? SYNC_WORD[3-i] : 1'b0;
			rx_cover <= (i >= 4 && i < 12);
			rx_crc_slot <= (i >= 12);
			rx_bit <= b;
			dsl_rx_data <= b;
		end
		@(posedge aclk);
		{rx_bit_valid, rx_cover, rx_crc_slot, rx_sync_slot} <= 4'h0;
		rx_frame_end <= 1'b1;
		rx_bit <= ~b; // released line shows no stale bit
		dsl_rx_data <= ~b;
		@(posedge aclk);
		rx_frame_end <= 1'b0;
	endtask
endmodule // dsl_peer_model

// ### verif/dsl_link_monitor_loopback_tb_top.sv
/*
 * self-checking bench for the dsl link monitor: axi4-lite register tasks,
 * peer frame traffic, second counters, alarms and loopbacks.
 * assumes the package and the peer model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module dsl_link_monitor_loopback_tb_top;
	import dslmon_pkg::*;
	localparam int SEC = 8000; // short second keeps the run small
	logic        aclk = 1'b0, aresetn = 1'b0, lp_rx = 1'b0, remote_sync_lost_in = 1'b0, e1_inband_loop = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, snr_in = 8'h00, e1_flags = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, tx_start = 1'b0, tx_bit_valid = 1'b0;
	logic        tx_cover = 1'b0, tx_crc_slot = 1'b0, tx_sync_slot = 1'b0, tx_sync_pat = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_line_bit, lp_tx;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic        rx_bit_valid, rx_bit, rx_cover, rx_crc_slot, rx_sync_slot, rx_sync_pat, rx_frame_end;
	logic        dsl_rx_data, line_alarm, line_open, loop_internal, remote_loop_req, retrain;
	logic [2:0]  loop_mode;
	int          num_errors = 0, total_checks = 0, cyc = 0, n_retrain = 0;

	always #12.5 aclk = ~aclk;
	// cycles since release, so traffic lands inside one second
	always @(posedge aclk) cyc <= aresetn ? cyc + 1 : 0;
	// count retrain pulses; release timing then need not be exact
	always @(posedge aclk) if (retrain === 1'b1) n_retrain <= n_retrain + 1;

	dsl_link_monitor_loopback #(.SEC_CYC(SEC), .CW(16)) i_dsl_link_monitor_loopback (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_start,
		.tx_bit_valid, .tx_cover, .tx_crc_slot, .tx_sync_slot, .tx_sync_pat, .tx_line_bit, .rx_bit_valid,
		.rx_bit, .rx_cover, .rx_crc_slot, .rx_sync_slot, .rx_sync_pat, .rx_frame_end, .dsl_rx_data,
		.lp_rx, .lp_tx, .remote_sync_lost_in, .snr_in, .e1_flags, .e1_inband_loop, .line_alarm,
		.loop_mode, .line_open, .loop_internal, .remote_loop_req, .retrain);
	dsl_peer_model i_dsl_peer_model (.aclk, .rx_bit_valid, .rx_bit, .rx_cover, .rx_crc_slot,
		.rx_sync_slot, .rx_sync_pat, .rx_frame_end, .dsl_rx_data);

	// register write: address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic done;
		done = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) begin
				done = 1'b1;
				s_axi_bready <= 1'b0;
				`CHK(s_axi_bresp, r)
			end
		end
		// one idle edge so a next call does not raise bready in this step
		@(posedge aclk);
	endtask

	// register read with expected data and response
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		logic done;
		done = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) begin
				done = 1'b1;
				s_axi_rready <= 1'b0;
				`CHK(s_axi_rdata, e)
				`CHK(s_axi_rresp, r)
			end
		end
		// one idle edge so a next call does not raise rready in this step
		@(posedge aclk);
	endtask

	// park just after a second boundary
	task automatic next_sec;
		@(posedge aclk);
		while (cyc % SEC != 20) @(posedge aclk);
	endtask

	task automatic frames(input int n, input logic bad_crc, input logic bad_sync);
		repeat (n) i_dsl_peer_model.send_frame(bad_crc, bad_sync);
	endtask

	// one transmit slot: kind is {sync, covered, check}, d feeds pattern and port
	task automatic tx_slot(input logic [2:0] kind, input logic d, input logic e);
		{tx_sync_slot, tx_cover, tx_crc_slot} <= kind;
		tx_sync_pat <= d;
		lp_rx <= d;
		tx_bit_valid <= 1'b1;
		@(posedge aclk);
		tx_bit_valid <= 1'b0;
		@(posedge aclk);
		`CHK(tx_line_bit, e)
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task automatic finish_test;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// watchdog sized well above the expected four seconds of traffic
	initial begin
		wait_cyc(90000);
		num_errors++;
		$display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		finish_test;
	end

	// main sequence
	initial begin
		logic [5:0] c;
		logic [7:0] pat;
		c = 6'h00;
		pat = 8'h9d;
		wait_cyc(4);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(CTRL_OFS, CTRL_RST, RESP_OKAY);
		rd(STAT_OFS, 32'h0, RESP_OKAY);
		rd(8'h18, 32'h0, RESP_SLVERR);
		wr(STAT_OFS, 32'hffff_ffff, RESP_SLVERR);
		// transmit frame: sync word, covered port bits, then the check word
		tx_start <= 1'b1;
		@(posedge aclk);
		tx_start <= 1'b0;
		for (int i = 0; i < 4; i++)
			tx_slot(3'b100, i[0], i[0]);
		for (int i = 7; i >= 0; i--) begin
			c = {c[4:0], 1'b0} ^ ((c[5] ^ pat[i]) ? CRC_POLY : 6'h00);
			tx_slot(3'b010, pat[i], pat[i]);
		end
		for (int i = 5; i >= 0; i--)
			tx_slot(3'b001, 1'b0, c[i]);
		snr_in <= 8'h3c;
		// one short of the severe limit, then exactly at it
		next_sec;
		frames(149, 1'b1, 1'b0);
		next_sec;
		rd(ERRSEC_OFS, 32'h1, RESP_OKAY);
		rd(SEVSEC_OFS, 32'h0, RESP_OKAY);
		rd(SNR_OFS, 32'h3c, RESP_OKAY);
		snr_in <= 8'h41;
		frames(150, 1'b1, 1'b0);
		next_sec;
		rd(ERRSEC_OFS, 32'h2, RESP_OKAY);
		rd(SEVSEC_OFS, 32'h1, RESP_OKAY);
		rd(SNR_OFS, 32'h41, RESP_OKAY);
		rd(UNAVSEC_OFS, 32'h0, RESP_OKAY);
		// four bad sync words are tolerated, the fifth loses sync
		frames(4, 1'b0, 1'b1);
		@(posedge aclk);
		`CHK(line_alarm, 1'b0)
		frames(1, 1'b0, 1'b1);
		@(posedge aclk);
		`CHK(line_alarm, 1'b1)
		remote_sync_lost_in <= 1'b1;
		// the far-end report takes one edge to reach status
		wait_cyc(2);
		rd(STAT_OFS, 32'h3, RESP_OKAY);
		remote_sync_lost_in <= 1'b0;
		frames(1, 1'b0, 1'b0);
		@(posedge aclk);
		`CHK(line_alarm, 1'b0)
		next_sec;
		rd(UNAVSEC_OFS, 32'h1, RESP_OKAY);
		rd(ERRSEC_OFS, 32'h2, RESP_OKAY);
		e1_flags <= 8'ha5;
		rd(STAT_OFS, 32'h0, RESP_OKAY);
		wr(CTRL_OFS, 32'h10, RESP_OKAY);
		rd(STAT_OFS, 32'ha500, RESP_OKAY);
		wr(CTRL_OFS, 32'h110, RESP_OKAY);
		rd(ERRSEC_OFS, 32'h0, RESP_OKAY);
		rd(SEVSEC_OFS, 32'h0, RESP_OKAY);
		rd(UNAVSEC_OFS, 32'h0, RESP_OKAY);
		// loopbacks, each new mode replacing the one before
		wr(CTRL_OFS, 32'h11, RESP_OKAY);
		lp_rx <= 1'b1;
		wait_cyc(3);
		`CHK(loop_mode, LB_LOCAL)
		`CHK(lp_tx, 1'b1)
		lp_rx <= 1'b0;
		wait_cyc(3);
		`CHK(lp_tx, 1'b0)
		wr(CTRL_OFS, 32'h12, RESP_OKAY);
		wait_cyc(3);
		`CHK(loop_mode, LB_DSL)
		`CHK(n_retrain, 1)
		`CHK(line_open, 1'b1)
		`CHK(line_alarm, 1'b1)
		// port bit set opposite to the line bit, so only the loop passes
		tx_slot(3'b000, ~dsl_rx_data, dsl_rx_data);
		wr(CTRL_OFS, 32'h14, RESP_OKAY);
		wait_cyc(3);
		`CHK(loop_internal, 1'b1)
		`CHK(line_open, 1'b0)
		`CHK(lp_tx, 1'b1)
		wr(CTRL_OFS, 32'h13, RESP_OKAY);
		wait_cyc(3);
		`CHK(remote_loop_req, 1'b1)
		`CHK(loop_internal, 1'b0)
		`CHK(n_retrain, 3)
		wr(CTRL_OFS, 32'h10, RESP_OKAY);
		wait_cyc(3);
		`CHK(loop_mode, LB_NONE)
		`CHK(n_retrain, 4)
		frames(1, 1'b0, 1'b0);
		@(posedge aclk);
		`CHK(line_alarm, 1'b0)
		e1_inband_loop <= 1'b1;
		@(posedge aclk);
		e1_inband_loop <= 1'b0;
		wait_cyc(3);
		`CHK(loop_mode, LB_LOCAL)
		finish_test;
	end
endmodule // dsl_link_monitor_loopback_tb_top
